// ==== ivg_defines.vh ====
// constants, register map and field layout for the input voltage guard
//
// Functional notes
// - a sample above the over-voltage warning limit sets the catch-all and input summary bits, the over-voltage warning flag and pulls the alert line;
//   the code sets them only on a crossing, not again while samples stay above the limit.
// - a sample crossing below the under-voltage warning limit sets the catch-all and input summary bits, the under-voltage warning flag and pulls the alert line.
// - after an under-voltage fault the fault counts as gone only once input voltage rises above the under-voltage warning limit.
// - every limit holds a signed 5-bit exponent N over a signed 11-bit mantissa Y, worth Y times 2 to the N volts, 0 to 19 V.
// - at reset the under-voltage warning limit takes 1.10 times the strapped lockout level and the fault limit the strapped level itself.
// - the input limit and action registers are global to both channels, readable, writable and write protected.
// - an under-voltage fault pulls the alert line and sets a fault flag that only the clear-faults command removes.
// - action bits 7:6 equal to 10 disable the output and retry per bits 5:3; codes 00 and 01 are unused.
// - action bits 7:6 equal to 11 hold the output off while the fault persists and re-enable it once above the warning limit.
// - retry bits 000 never retry and keep the output off until the fault is cleared; 001 to 110 are unused.
// - retry bits 111 restart without end until switched off, bias is lost or another fault shuts down.
// - in continuous retry each attempt starts only after input voltage is above the under-voltage warning limit.
// - restart attempts are spaced by (bits 2:0 plus one) times 35 ms, 35 ms to 280 ms.
// - the action register resets to continuous retry with 280 ms spacing.
`ifndef IVG_DEFINES_VH
`define IVG_DEFINES_VH

// =====================================================================
// command codes of the global input registers
`define IVG_ADDR_OV_WARN      8'h57
`define IVG_ADDR_UV_WARN      8'h58
`define IVG_ADDR_UV_FAULT     8'h59
`define IVG_ADDR_UV_ACTION    8'h5a

// =====================================================================
// reset values
`define IVG_RST_OV_WARN       16'hd360
`define IVG_RST_UV_ACTION     8'hbf

// =====================================================================
// linear-11 field layout
`define IVG_L11_EXP_HI        15
`define IVG_L11_EXP_LO        11
`define IVG_L11_MAN_HI        10
`define IVG_L11_MAN_LO        0
`define IVG_FIX_FRAC          16

// =====================================================================
// action register fields and codes
`define IVG_ACT_MODE_HI       7
`define IVG_ACT_MODE_LO       6
`define IVG_ACT_RETRY_HI      5
`define IVG_ACT_RETRY_LO      3
`define IVG_ACT_DELAY_HI      2
`define IVG_ACT_DELAY_LO      0
`define IVG_MODE_RETRY        2'h2
`define IVG_MODE_HOLD         2'h3
`define IVG_RETRY_NONE        3'h0
`define IVG_RETRY_FOREVER     3'h7

// =====================================================================
// lockout scaling, 1.10 as 11 over 10
`define IVG_UVW_MUL           15'h000b
`define IVG_UVW_DIV           15'h000a
`define IVG_MAN_MAX           15'h03ff

// =====================================================================
// timing
`define IVG_CLK_HZ            25000000
`define IVG_RETRY_STEP_MS     35
`define IVG_RETRY_STEP_CYCLES ((`IVG_CLK_HZ / 1000) * `IVG_RETRY_STEP_MS)

`endif

// ==== ivg_retry_timer.v ====
// retry spacing timer: counts whole 35 ms steps after a start pulse
`timescale 1ns/100ps

module ivg_retry_timer #(
  parameter STEP_CYCLES = 875000,
  parameter CNT_W       = 20
) (
  // clock and reset
  input  wire       ref_clk,
  input  wire       rst,
  // control
  input  wire       start,
  input  wire [2:0] delay_code,
  // status
  output reg        done_r
);

  reg [CNT_W-1:0] div_r;
  reg [3:0]       steps_r;
  reg             busy_r;
  wire            step_en;

  // =====================================================================
  // step divider, restarted with every start so the first step is whole
  assign step_en = busy_r && (div_r == (STEP_CYCLES[CNT_W-1:0] - 1'b1));

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_r <= {CNT_W{1'b0}};
    end else if (start || step_en) begin
      div_r <= {CNT_W{1'b0}};
    end else if (busy_r) begin
      div_r <= div_r + 1'b1;
    end
  end

  // =====================================================================
  // step counter, (code + 1) steps before done
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      steps_r <= 4'h0;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
    end else if (start) begin
      steps_r <= {1'b0, delay_code} + 4'h1;
      busy_r  <= 1'b1;
      done_r  <= 1'b0;
    end else if (step_en) begin
      steps_r <= steps_r - 4'h1;
      if (steps_r == 4'h1) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
      end
    end
  end

endmodule // ivg_retry_timer

// ==== ivg_input_voltage_guard.v ====
// input voltage supervision: limits, status flags, alert and under-voltage response
`timescale 1ns/100ps
`include "ivg_defines.vh"

module ivg_input_voltage_guard #(
  parameter RETRY_STEP_CYCLES = `IVG_RETRY_STEP_CYCLES,
  parameter TMR_W             = 20
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // strapped lockout level, linear-11, caught after reset release
  input  wire [15:0] strapped_lockout_level,
  // input voltage measurement, linear-11
  input  wire [15:0] vin_sample,
  input  wire        vin_sample_valid,
  // global command register access
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr_en,
  input  wire [15:0] reg_wr_data,
  input  wire        reg_rd_en,
  input  wire        write_protect,
  input  wire        clear_faults,
  output reg  [15:0] reg_rd_data_r,
  output reg         reg_rd_valid_r,
  output reg         reg_ack_r,
  // output control
  input  wire        run_request,
  output reg         output_enable_r,
  // status bits
  output reg         catch_all_summary_bit_r,
  output reg         input_summary_bit_r,
  output reg         input_overvoltage_warning_flag_r,
  output reg         input_undervoltage_warning_flag_r,
  output reg         input_undervoltage_fault_flag_r,
  // open-drain alert line
  output reg         alert_line_out_r,
  output reg         alert_line_oe_n_r
);

  // response states
  localparam [1:0] ST_RUN   = 2'h0;
  localparam [1:0] ST_LATCH = 2'h1;
  localparam [1:0] ST_HOLD  = 2'h2;
  localparam [1:0] ST_RETRY = 2'h3;

  // =====================================================================
  // linear-11 to signed fixed point with 16 fraction bits
  function signed [47:0] lin11_fix;
    input [15:0] v;
    reg signed [47:0] y;
    integer           sh;
    begin
      y  = {{37{v[`IVG_L11_MAN_HI]}}, v[`IVG_L11_MAN_HI:`IVG_L11_MAN_LO]};
      sh = $signed(v[`IVG_L11_EXP_HI:`IVG_L11_EXP_LO]) + `IVG_FIX_FRAC;
      if (sh >= 0) begin
        lin11_fix = y <<< sh;
      end else begin
        lin11_fix = y >>> (-sh);
      end
    end
  endfunction

  // =====================================================================
  // registers
  reg  [15:0] ov_warn_r;
  reg  [15:0] uv_warn_r;
  reg  [15:0] uv_fault_r;
  reg  [7:0]  uv_action_r;
  reg         strap_done_r;
  reg         above_ovw_r;
  reg         below_uvw_r;
  reg         below_uvf_r;
  reg         uv_fault_active_r;
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg         timer_start_r;
  wire        timer_done;

  // =====================================================================
  // strap scaling: mantissa times 11 over 10, renormalised on overflow
  wire [14:0] strap_x11;
  wire [14:0] strap_q;
  wire [15:0] strap_uvw;
  wire [4:0]  strap_exp_up;

  assign strap_x11    = {4'h0, strapped_lockout_level[10:0]} * `IVG_UVW_MUL;
  assign strap_q      = strap_x11 / `IVG_UVW_DIV;
  assign strap_exp_up = strapped_lockout_level[15:11] + 5'h01;
  assign strap_uvw    = (strap_q > `IVG_MAN_MAX) ? {strap_exp_up, strap_q[11:1]}
                                                 : {strapped_lockout_level[15:11],
                                                    strap_q[10:0]};

  // =====================================================================
  // limit comparisons against the newest sample
  wire signed [47:0] vin_fix;
  wire               vin_gt_ovw;
  wire               vin_lt_uvw;
  wire               vin_gt_uvw;
  wire               vin_lt_uvf;

  assign vin_fix    = lin11_fix(vin_sample);
  assign vin_gt_ovw = vin_fix > lin11_fix(ov_warn_r);
  assign vin_lt_uvw = vin_fix < lin11_fix(uv_warn_r);
  assign vin_gt_uvw = vin_fix > lin11_fix(uv_warn_r);
  assign vin_lt_uvf = vin_fix < lin11_fix(uv_fault_r);

  // crossing pulses, only on a new sample
  wire set_ovw;
  wire set_uvw;
  wire set_uvf;
  wire fault_gone;

  assign set_ovw    = vin_sample_valid && vin_gt_ovw && !above_ovw_r;
  assign set_uvw    = vin_sample_valid && vin_lt_uvw && !below_uvw_r;
  assign set_uvf    = vin_sample_valid && vin_lt_uvf && !below_uvf_r;
  assign fault_gone = vin_sample_valid && vin_gt_uvw;

  // =====================================================================
  // register file; the limits are global, one copy for both channels
  wire wr_ok;
  assign wr_ok = reg_wr_en && !write_protect;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ov_warn_r    <= `IVG_RST_OV_WARN;
      uv_warn_r    <= 16'h0000;
      uv_fault_r   <= 16'h0000;
      uv_action_r  <= `IVG_RST_UV_ACTION;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      // strap pins are read one edge after release, never under reset
      uv_warn_r    <= strap_uvw;
      uv_fault_r   <= strapped_lockout_level;
      strap_done_r <= 1'b1;
    end else if (wr_ok) begin
      case (reg_addr)
        `IVG_ADDR_OV_WARN:   ov_warn_r   <= reg_wr_data;
        `IVG_ADDR_UV_WARN:   uv_warn_r   <= reg_wr_data;
        `IVG_ADDR_UV_FAULT:  uv_fault_r  <= reg_wr_data;
        `IVG_ADDR_UV_ACTION: uv_action_r <= reg_wr_data[7:0];
        default: ;
      endcase
    end
  end

  // =====================================================================
  // read port, one cycle latency, unmapped codes read zero
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rd_data_r  <= 16'h0000;
      reg_rd_valid_r <= 1'b0;
      reg_ack_r      <= 1'b0;
    end else begin
      reg_rd_valid_r <= reg_rd_en;
      // ack marks every unprotected write after strapping, unmapped codes included; protected writes get none
      reg_ack_r      <= wr_ok && strap_done_r;
      if (reg_rd_en) begin
        case (reg_addr)
          `IVG_ADDR_OV_WARN:   reg_rd_data_r <= ov_warn_r;
          `IVG_ADDR_UV_WARN:   reg_rd_data_r <= uv_warn_r;
          `IVG_ADDR_UV_FAULT:  reg_rd_data_r <= uv_fault_r;
          `IVG_ADDR_UV_ACTION: reg_rd_data_r <= {8'h00, uv_action_r};
          default:             reg_rd_data_r <= 16'h0000;
        endcase
      end
    end
  end

  // =====================================================================
  // level memory of each comparison, so flags fire only on a crossing
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      above_ovw_r       <= 1'b0;
      below_uvw_r       <= 1'b0;
      below_uvf_r       <= 1'b0;
      uv_fault_active_r <= 1'b0;
    end else if (vin_sample_valid) begin
      above_ovw_r <= vin_gt_ovw;
      below_uvw_r <= vin_lt_uvw;
      below_uvf_r <= vin_lt_uvf;
      // fault persists through the band between fault and warning limits
      if (set_uvf || vin_lt_uvf) begin
        uv_fault_active_r <= 1'b1;
      end else if (fault_gone) begin
        uv_fault_active_r <= 1'b0;
      end
    end
  end

  // =====================================================================
  // sticky status; a set in the clearing cycle wins over the clear
  wire any_set;
  assign any_set = set_ovw || set_uvw || set_uvf;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      input_overvoltage_warning_flag_r  <= 1'b0;
      input_undervoltage_warning_flag_r <= 1'b0;
      input_undervoltage_fault_flag_r   <= 1'b0;
      catch_all_summary_bit_r           <= 1'b0;
      input_summary_bit_r               <= 1'b0;
    end else begin
      input_overvoltage_warning_flag_r  <= set_ovw |
        (input_overvoltage_warning_flag_r & ~clear_faults);
      input_undervoltage_warning_flag_r <= set_uvw |
        (input_undervoltage_warning_flag_r & ~clear_faults);
      input_undervoltage_fault_flag_r   <= set_uvf |
        (input_undervoltage_fault_flag_r & ~clear_faults);
      catch_all_summary_bit_r           <= any_set |
        (catch_all_summary_bit_r & ~clear_faults);
      input_summary_bit_r               <= any_set |
        (input_summary_bit_r & ~clear_faults);
    end
  end

  // =====================================================================
  // alert line: held low while any flag stands, released by clear
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      alert_line_out_r  <= 1'b0;
      alert_line_oe_n_r <= 1'b1;
    end else begin
      alert_line_out_r  <= 1'b0;
      alert_line_oe_n_r <= ~(any_set | (~alert_line_oe_n_r & ~clear_faults));
    end
  end

  // =====================================================================
  // under-voltage response state machine
  wire [1:0] act_mode;
  wire [2:0] act_retry;
  wire [2:0] act_delay;

  assign act_mode  = uv_action_r[`IVG_ACT_MODE_HI:`IVG_ACT_MODE_LO];
  assign act_retry = uv_action_r[`IVG_ACT_RETRY_HI:`IVG_ACT_RETRY_LO];
  assign act_delay = uv_action_r[`IVG_ACT_DELAY_HI:`IVG_ACT_DELAY_LO];

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        // modes 00 and 01 are unused and leave the output running
        if (set_uvf && (act_mode == `IVG_MODE_HOLD)) begin
          state_nxt = ST_HOLD;
        end else if (set_uvf && (act_mode == `IVG_MODE_RETRY)) begin
          if (act_retry == `IVG_RETRY_FOREVER) begin
            state_nxt = ST_RETRY;
          end else begin
            state_nxt = ST_LATCH;
          end
        end
      end
      ST_LATCH: begin
        // unused retry codes behave as no retry
        if (clear_faults) begin
          state_nxt = ST_RUN;
        end
      end
      ST_HOLD: begin
        if (!uv_fault_active_r) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RETRY: begin
        // attempt needs both the spacing elapsed and voltage back above warning
        if (timer_done && !uv_fault_active_r) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
    // switching off by enable or command ends any retry loop
    if (!run_request) begin
      state_nxt = ST_RUN;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r         <= ST_RUN;
      timer_start_r   <= 1'b0;
      output_enable_r <= 1'b0;
    end else begin
      state_r         <= state_nxt;
      // spacing counts from the shutdown that precedes each attempt
      timer_start_r   <= (state_r != ST_RETRY) && (state_nxt == ST_RETRY);
      output_enable_r <= run_request && strap_done_r && (state_nxt == ST_RUN);
    end
  end

  // =====================================================================
  // retry spacing timer
  ivg_retry_timer #(
    .STEP_CYCLES (RETRY_STEP_CYCLES),
    .CNT_W       (TMR_W)
  ) u_retry_timer (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .start      (timer_start_r),
    .delay_code (act_delay),
    .done_r     (timer_done)
  );

endmodule // ivg_input_voltage_guard

// ==== ivg_host_model.sv ====
// host-side model driving the guard's command register port
`timescale 1ns/100ps

module ivg_host_model (
  // clock
  input  wire        ref_clk,
  // requests to the guard
  output reg  [7:0]  reg_addr,
  output reg         reg_wr_en,
  output reg  [15:0] reg_wr_data,
  output reg         reg_rd_en,
  output reg         write_protect,
  output reg         clear_faults,
  // answers from the guard
  input  wire [15:0] reg_rd_data_r,
  input  wire        reg_rd_valid_r,
  input  wire        reg_ack_r
);
  // =====================================================================
  // idle levels; data is inverted after use so nothing stale looks valid
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 16'h0000;
    reg_rd_en = 1'b0;
    write_protect = 1'b0;
    clear_faults = 1'b0;
  end

  // one write, ack taken the cycle after the strobe
  task wr(input [7:0] a, input [15:0] d, output ack);
    begin
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      reg_wr_data = d;
      reg_wr_en = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_wr_en = 1'b0;
      reg_wr_data = ~d;
      ack = reg_ack_r;
    end
  endtask

  // one read, data and valid taken the cycle after the strobe
  task rd(input [7:0] a, output [15:0] q, output v);
    begin
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      reg_rd_en = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_rd_en = 1'b0;
      q = reg_rd_data_r;
      v = reg_rd_valid_r;
    end
  endtask

  // clear-faults command, one cycle
  task clr;
    begin
      @(posedge ref_clk);
      #1;
      clear_faults = 1'b1;
      @(posedge ref_clk);
      #1;
      clear_faults = 1'b0;
    end
  endtask

  // write protection level
  task prot(input b);
    begin
      @(posedge ref_clk);
      #1;
      write_protect = b;
    end
  endtask
endmodule // ivg_host_model

// ==== ivg_guard_assertions.sv ====
// concurrent checks on the guard's ports
`timescale 1ns/100ps

module ivg_guard_assertions (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // requests
  input wire vin_sample_valid,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire write_protect,
  input wire clear_faults,
  input wire run_request,
  // answers and status
  input wire reg_rd_valid_r,
  input wire reg_ack_r,
  input wire output_enable_r,
  input wire catch_all_summary_bit_r,
  input wire input_summary_bit_r,
  input wire input_overvoltage_warning_flag_r,
  input wire input_undervoltage_warning_flag_r,
  input wire input_undervoltage_fault_flag_r,
  input wire alert_line_out_r,
  input wire alert_line_oe_n_r
);
  // =====================================================================
  // one domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // flag going up, and a clear with no competing sample
  sequence s_rise(f);
    !f ##1 f;
  endsequence
  sequence s_clear;
    clear_faults && !vin_sample_valid;
  endsequence

  property p_rd_answer;
    reg_rd_en |=> reg_rd_valid_r;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");

  property p_wp_refuse;
    reg_wr_en && write_protect |=> !reg_ack_r;
  endproperty
  a_wp_refuse: assert property (p_wp_refuse) else $error("protected write acked");

  // the first edge after reset ignores writes, hence the past term
  property p_wr_ack;
    reg_wr_en && !write_protect && !$past(rst) |=> reg_ack_r;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write not acked");

  property p_ov_set;
    s_rise(input_overvoltage_warning_flag_r) |-> $past(vin_sample_valid)
      && catch_all_summary_bit_r && input_summary_bit_r && !alert_line_oe_n_r;
  endproperty
  a_ov_set: assert property (p_ov_set) else $error("ov warning set badly");

  property p_uvw_set;
    s_rise(input_undervoltage_warning_flag_r) |-> $past(vin_sample_valid)
      && catch_all_summary_bit_r && input_summary_bit_r && !alert_line_oe_n_r;
  endproperty
  a_uvw_set: assert property (p_uvw_set) else $error("uv warning set badly");

  property p_uvf_set;
    s_rise(input_undervoltage_fault_flag_r) |-> $past(vin_sample_valid) && !alert_line_oe_n_r;
  endproperty
  a_uvf_set: assert property (p_uvf_set) else $error("uv fault set badly");

  property p_sticky;
    input_undervoltage_fault_flag_r && !clear_faults |=> input_undervoltage_fault_flag_r;
  endproperty
  a_sticky: assert property (p_sticky) else $error("fault flag lost");

  property p_clear;
    s_clear |=> !catch_all_summary_bit_r && !input_summary_bit_r
      && !input_overvoltage_warning_flag_r && !input_undervoltage_warning_flag_r
      && !input_undervoltage_fault_flag_r && alert_line_oe_n_r;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left status");

  property p_run_off;
    !run_request |=> !output_enable_r;
  endproperty
  a_run_off: assert property (p_run_off) else $error("output on without run");

  property p_off_cause;
    $fell(output_enable_r) |-> !$past(run_request) || $past(vin_sample_valid);
  endproperty
  a_off_cause: assert property (p_off_cause) else $error("output dropped uncaused");

  property p_alert_low;
    !alert_line_out_r;
  endproperty
  a_alert_low: assert property (p_alert_low) else $error("alert drives high");
endmodule // ivg_guard_assertions

bind ivg_input_voltage_guard ivg_guard_assertions chk_u (
  .ref_clk(ref_clk), .rst(rst), .vin_sample_valid(vin_sample_valid),
  .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .write_protect(write_protect),
  .clear_faults(clear_faults), .run_request(run_request),
  .reg_rd_valid_r(reg_rd_valid_r), .reg_ack_r(reg_ack_r),
  .output_enable_r(output_enable_r), .catch_all_summary_bit_r(catch_all_summary_bit_r),
  .input_summary_bit_r(input_summary_bit_r),
  .input_overvoltage_warning_flag_r(input_overvoltage_warning_flag_r),
  .input_undervoltage_warning_flag_r(input_undervoltage_warning_flag_r),
  .input_undervoltage_fault_flag_r(input_undervoltage_fault_flag_r),
  .alert_line_out_r(alert_line_out_r), .alert_line_oe_n_r(alert_line_oe_n_r));

// ==== ivg_input_voltage_guard_test.sv ====
// self-checking bench for the input voltage guard
`timescale 1ns/100ps
`include "ivg_defines.vh"

module ivg_input_voltage_guard_test;
  // =====================================================================
  // short retry step keeps the run brief; samples share exponent -4
  localparam STEP = 10;
  localparam [15:0] V9 = 16'he090, V10H = 16'he0a8, V12 = 16'he0c0;
  localparam [15:0] V13 = 16'he0d0, V14 = 16'he0e0;
  reg         ref_clk;
  reg         rst;
  reg  [15:0] vin;
  reg         vin_valid;
  reg         run_req;
  integer     error_cnt, cmp_count, i, d;
  wire [7:0]  addr;
  wire [15:0] wdat, rdat;
  wire        wen, ren, wp, clrf, rval, ack, oe, ca, ins, ovf, uvw, uvf, aout, aoen;
  wire [15:0] st = {8'h00, aout, oe, ca, ins, ovf, uvw, uvf, aoen};

  ivg_input_voltage_guard #(.RETRY_STEP_CYCLES(STEP), .TMR_W(20)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .strapped_lockout_level(16'he0a0),
    .vin_sample(vin), .vin_sample_valid(vin_valid), .reg_addr(addr),
    .reg_wr_en(wen), .reg_wr_data(wdat), .reg_rd_en(ren), .write_protect(wp),
    .clear_faults(clrf), .reg_rd_data_r(rdat), .reg_rd_valid_r(rval),
    .reg_ack_r(ack), .run_request(run_req), .output_enable_r(oe),
    .catch_all_summary_bit_r(ca), .input_summary_bit_r(ins),
    .input_overvoltage_warning_flag_r(ovf), .input_undervoltage_warning_flag_r(uvw),
    .input_undervoltage_fault_flag_r(uvf), .alert_line_out_r(aout),
    .alert_line_oe_n_r(aoen));

  ivg_host_model host_u (
    .ref_clk(ref_clk), .reg_addr(addr), .reg_wr_en(wen), .reg_wr_data(wdat),
    .reg_rd_en(ren), .write_protect(wp), .clear_faults(clrf),
    .reg_rd_data_r(rdat), .reg_rd_valid_r(rval), .reg_ack_r(ack));

  // =====================================================================
  // comparison, verdict and helpers
  task chk(input [95:0] nm, input [15:0] got, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("Error %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask

  task rdchk(input [7:0] a, input [15:0] exp);
    reg [15:0] q;
    reg        v;
    begin
      host_u.rd(a, q, v);
      chk("rd valid", {15'h0000, v}, 16'h0001);
      chk("rd data", q, exp);
    end
  endtask

  task wrchk(input [7:0] a, input [15:0] dat, input exp);
    reg k;
    begin
      host_u.wr(a, dat, k);
      chk("wr ack", {15'h0000, k}, {15'h0000, exp});
    end
  endtask

  // one sample pulse; flags are settled when this returns
  task samp(input [15:0] v);
    begin
      @(posedge ref_clk);
      #1;
      vin = v;
      vin_valid = 1'b1;
      @(posedge ref_clk);
      #1;
      vin_valid = 1'b0;
      vin = ~v;
    end
  endtask

  task wait_oe(input integer n, input e);
    begin
      repeat (n) @(posedge ref_clk);
      #1;
      chk("oe", {15'h0000, oe}, {15'h0000, e});
    end
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // watchdog, far beyond the under one thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt = error_cnt + 1;
    give_verdict;
  end

  // =====================================================================
  // main sequence
  initial begin
    error_cnt = 0;
    cmp_count = 0;
    rst = 1'b1;
    vin = 16'h0000;
    vin_valid = 1'b0;
    run_req = 1'b0;
    repeat (20) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge ref_clk);
    rdchk(`IVG_ADDR_OV_WARN, 16'hd360);
    rdchk(`IVG_ADDR_UV_WARN, 16'he0b0);
    rdchk(`IVG_ADDR_UV_FAULT, 16'he0a0);
    rdchk(`IVG_ADDR_UV_ACTION, 16'h00bf);
    host_u.prot(1'b1);
    wrchk(`IVG_ADDR_OV_WARN, 16'h0000, 1'b0);
    host_u.prot(1'b0);
    rdchk(`IVG_ADDR_OV_WARN, 16'hd360);
    wrchk(`IVG_ADDR_OV_WARN, 16'hd340, 1'b1);
    rdchk(`IVG_ADDR_OV_WARN, 16'hd340);
    wrchk(`IVG_ADDR_UV_ACTION, 16'hffbf, 1'b1);
    rdchk(`IVG_ADDR_UV_ACTION, 16'h00bf);
    wrchk(8'h50, 16'h1234, 1'b1);
    rdchk(8'h50, 16'h0000);
    // same 11 V and 10 V under other exponents, so later compares mix exponents
    wrchk(`IVG_ADDR_UV_WARN, 16'h000b, 1'b1);
    rdchk(`IVG_ADDR_UV_WARN, 16'h000b);
    wrchk(`IVG_ADDR_UV_FAULT, 16'hd280, 1'b1);
    rdchk(`IVG_ADDR_UV_FAULT, 16'hd280);
    // limits across exponents, strict compare, crossing only
    run_req = 1'b1;
    samp(V12);
    chk("status", st, 16'h0041);
    samp(V13);
    chk("status", st, 16'h0041);
    samp(V14);
    chk("status", st, 16'h0078);
    host_u.clr;
    chk("status", st, 16'h0041);
    samp(V14);
    chk("status", st, 16'h0041);
    samp(V12);
    samp(V10H);
    chk("status", st, 16'h0074);
    // fault under default action; hysteresis blocks restart
    samp(V9);
    chk("status", st, 16'h0036);
    samp(V10H);
    repeat (90) @(posedge ref_clk);
    #1;
    chk("status", st, 16'h0036);
    samp(V12);
    wait_oe(2, 1'b1);
    chk("status", st, 16'h0076);
    host_u.clr;
    // retry spacing for every delay code
    for (d = 0; d < 8; d = d + 1) begin
      wrchk(`IVG_ADDR_UV_ACTION, 16'h00b8 | d[15:0], 1'b1);
      samp(V9);
      samp(V12);
      // timer starts the edge after shutdown; restart one edge after it is done
      wait_oe((d + 1) * STEP - 1, 1'b0);
      wait_oe(1, 1'b1);
    end
    // hold while the fault is present
    wrchk(`IVG_ADDR_UV_ACTION, 16'h00c0, 1'b1);
    samp(V9);
    wait_oe(0, 1'b0);
    samp(V10H);
    wait_oe(5, 1'b0);
    samp(V12);
    wait_oe(2, 1'b1);
    // no retry, and an unused retry code acting alike
    for (i = 0; i < 2; i = i + 1) begin
      wrchk(`IVG_ADDR_UV_ACTION, i ? 16'h0098 : 16'h0080, 1'b1);
      samp(V9);
      samp(V12);
      wait_oe(100, 1'b0);
      host_u.clr;
      wait_oe(2, 1'b1);
    end
    // unused modes leave the output alone
    for (i = 0; i < 2; i = i + 1) begin
      wrchk(`IVG_ADDR_UV_ACTION, i ? 16'h007f : 16'h003f, 1'b1);
      samp(V9);
      chk("status", st, 16'h0076);
      host_u.clr;
      samp(V12);
    end
    // switched off by the run request
    @(posedge ref_clk);
    #1;
    run_req = 1'b0;
    wait_oe(2, 1'b0);
    give_verdict;
  end
endmodule // ivg_input_voltage_guard_test
